// ### hdl/usart_consts.vh
// constants for the serial transceiver configuration block
// assumes an 8-bit register port with 3-bit word offsets
`ifndef USART_CONSTS_VH
`define USART_CONSTS_VH

// register offsets
`define OFS_DATA    3'h0
`define OFS_STATUS  3'h1
`define OFS_INTERRUPT_LEVEL_CONTROL   3'h3
`define OFS_ENABLE_AND_OPTION_CONTROL   3'h4
`define OFS_FRAME_FORMAT_CONTROL   3'h5
`define OFS_BAUDL   3'h6
`define OFS_BAUDH   3'h7

// reset values
`define STATUS_RST  8'h20
`define FRAME_FORMAT_CONTROL_RST   8'h06
`define ZERO8       8'h00

// enable_and_option_control fields
`define CB_RXEN     4
`define CB_TXEN     3
`define CB_DOUBLE   2
`define CB_MULTIPROC_ADDRESS_FILTER     1
`define CB_TX9      0

// frame_format_control fields
`define CC_MODE     7:6
`define CC_PAR_EN   5
`define CC_PAR_ODD  4
`define CC_STOP     3
`define CC_SIZE     2:0
`define CC_ORDER    2
`define CC_PHASE    1

// status fields
`define ST_RXC      7
`define ST_TXC      6

// communication modes
`define MODE_ASYNC  2'h0
`define MODE_SYNC   2'h1
`define MODE_INFRA  2'h2
`define MODE_SPI    2'h3

// character size codes
`define SIZE_5      3'h0
`define SIZE_6      3'h1
`define SIZE_7      3'h2
`define SIZE_8      3'h3
`define SIZE_9      3'h7

// timing: ticks per bit and fixed point baud counter (1/128 cycle units)
`define OS_NORMAL   5'h10
`define OS_DOUBLE   5'h08
`define SYNC_TICKS  5'h02
`define FRAC_ONE    27'h0000080
`define FRAC_SHIFT  4'h7

`endif

// ### hdl/usart_frame_and_baud_config.v
// serial transceiver: register port, baud generator, frame transmitter and receiver
// assumes one clock mclk, rxd asynchronous to it, register strobes synchronous to mclk
//
// Overview of operation
// R1 - async double speed: divide by 8
// R2 - double speed ignored in synchronous mode
// R3 - software keeps double speed off in infrared
// R4 - address filter drops frames without address
// R5 - ninth tx bit latched with data write
// R6 - mode field: async, sync, infrared, spi
// R7 - parity field: off, even, odd
// R8 - transmitter appends computed parity bit
// R9 - receiver checks parity, flags mismatch
// R10 - stop selector one/two, transmit only
// R11 - character size five to nine bits
// R12 - spi bit order lsb or msb first
// R13 - software keeps bit order during transfers
// R14 - spi clock phase picks sampling edge
// R15 - spi ignores parity, stop, speed, filter, ninth
// R16 - baud select twelve bits, two registers
// R17 - low baud write reloads prescaler
// R18 - software keeps baud steady while active
// R19 - scale is signed, minus eight reserved
// R20 - positive scale prescales, negative fractional
// R21 - short characters: upper bits zero
// R22 - received ninth bit shown in status
// R23 - high baud write alone does not reload
`timescale 1ns/1ns
`include "usart_consts.vh"

module usart_frame_and_baud_config (
    input  wire       mclk,
    input  wire       rstn,
    input  wire [2:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_stb,
    input  wire       rd_stb,
    output reg  [7:0] rdata,
    input  wire       rxd,
    output reg        txd,
    output reg        xck,
    output reg        xck_oe
);

////////////////////////////////////////////////////////////////////////////////
// reset release and pin synchronisers

reg rst_m_r;
reg rst_s_r;
reg rxd_m_r;
reg rxd_s_r;
reg rxd_d_r;

always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
        rst_m_r <= 1'b0;
        rst_s_r <= 1'b0;
    end else begin
        rst_m_r <= 1'b1;
        rst_s_r <= rst_m_r;
    end
end

always @(posedge mclk or negedge rst_s_r) begin
    if (!rst_s_r) begin
        rxd_m_r <= 1'b1;
        rxd_s_r <= 1'b1;
        rxd_d_r <= 1'b1;
    end else begin
        rxd_m_r <= rxd;
        rxd_s_r <= rxd_m_r;
        rxd_d_r <= rxd_s_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// configuration decode

reg  [5:0]  interrupt_level_control_r;
reg  [4:0]  enable_and_option_control_r;
reg  [7:0]  frame_format_control_r;
reg  [7:0]  baudl_r;
reg  [7:0]  baudh_r;
reg  [11:0] act_baud_select_r;
reg  [3:0]  act_scale_r;

wire [1:0] mode     = frame_format_control_r[`CC_MODE];
wire       is_spi   = (mode == `MODE_SPI);                        // R6
wire       clocked  = is_spi | (mode == `MODE_SYNC);              // R6
wire       dbl      = enable_and_option_control_r[`CB_DOUBLE] & ~clocked;             // R1 R2 R15
wire [4:0] bit_ticks = clocked ? `SYNC_TICKS : (dbl ? `OS_DOUBLE : `OS_NORMAL); // R1
wire       par_en   = ~is_spi & frame_format_control_r[`CC_PAR_EN];              // R7 R15
wire       odd      = frame_format_control_r[`CC_PAR_ODD];                       // R7
wire       two_stop = ~is_spi & frame_format_control_r[`CC_STOP];                // R10 R15
wire       multiproc_address_filter     = ~is_spi & enable_and_option_control_r[`CB_MULTIPROC_ADDRESS_FILTER];                // R15
wire       order    = frame_format_control_r[`CC_ORDER];
wire       phase    = frame_format_control_r[`CC_PHASE];
wire       rxen     = enable_and_option_control_r[`CB_RXEN];
wire       txen     = enable_and_option_control_r[`CB_TXEN];

function [3:0] nbits_of;
    input [2:0] c;
    begin
        case (c)                                                   // R11
            `SIZE_5: nbits_of = 4'h5;
            `SIZE_6: nbits_of = 4'h6;
            `SIZE_7: nbits_of = 4'h7;
            `SIZE_9: nbits_of = 4'h9;
            default: nbits_of = 4'h8;
        endcase
    end
endfunction

wire [3:0] n_cfg = is_spi ? 4'h8 : nbits_of(frame_format_control_r[`CC_SIZE]);

////////////////////////////////////////////////////////////////////////////////
// baud generator: down counter in 1/128 cycle units

function [26:0] reload_of;
    input [11:0] b;
    input [3:0]  s;
    reg   [2:0]  m;
    begin
        m = s[3] ? (~s[2:0] + 3'h1) : s[2:0];                     // R19
        if (s[3])
            reload_of = ({15'h0, b} << (`FRAC_SHIFT - {1'b0, m})) + `FRAC_ONE; // R20
        else
            reload_of = ({15'h0, b} + 27'h1) << ({1'b0, m} + `FRAC_SHIFT);     // R20
    end
endfunction

reg  [26:0] baud_cnt_r;
wire        tick   = (baud_cnt_r <= `FRAC_ONE);
wire [26:0] reload = reload_of(act_baud_select_r, act_scale_r);

wire wr_data  = wr_stb & (addr == `OFS_DATA);
wire wr_stat  = wr_stb & (addr == `OFS_STATUS);
wire wr_baudl = wr_stb & (addr == `OFS_BAUDL);
wire rd_data  = rd_stb & (addr == `OFS_DATA);

always @(posedge mclk or negedge rst_s_r) begin
    if (!rst_s_r)
        baud_cnt_r <= `FRAC_ONE;
    else if (wr_baudl)
        baud_cnt_r <= reload_of({baudh_r[3:0], wdata}, baudh_r[7:4]); // R17 R16
    else if (tick)
        baud_cnt_r <= baud_cnt_r + reload - `FRAC_ONE;            // R20
    else
        baud_cnt_r <= baud_cnt_r - `FRAC_ONE;
end

////////////////////////////////////////////////////////////////////////////////
// transmitter

reg  [8:0]  tx_hold_r;
reg         dre_r;
reg         txc_r;
reg         tx_busy_r;
reg  [12:0] tx_frame_r;
reg  [3:0]  tx_left_r;
reg  [4:0]  tx_tcnt_r;
reg  [7:0]  spi_rx_r;
reg  [12:0] frm;
reg  [8:0]  dat;
reg  [3:0]  len;
integer     i;

always @* begin
    frm = 13'h1fff;
    dat = 9'h000;
    len = 4'h8;
    for (i = 0; i < 9; i = i + 1)
        if (i < n_cfg)
            dat[i] = tx_hold_r[i];                                 // R21
    if (is_spi) begin
        for (i = 0; i < 8; i = i + 1)
            frm[i] = order ? tx_hold_r[i] : tx_hold_r[7-i];        // R12
    end else begin
        frm[0] = 1'b0;
        for (i = 0; i < 9; i = i + 1)
            if (i < n_cfg)
                frm[i+1] = dat[i];
        if (par_en)
            frm[n_cfg+4'h1] = ^dat ^ odd;                          // R8
        len = 4'h2 + n_cfg + {3'h0, par_en} + {3'h0, two_stop};    // R10
    end
end

wire tx_load    = txen & ~dre_r & ~tx_busy_r;
wire bit_end    = tick & tx_busy_r & (tx_tcnt_r == bit_ticks - 5'h1);
wire tx_done    = bit_end & (tx_left_r == 4'h1);
wire mid_strobe = tick & tx_busy_r & clocked & (tx_tcnt_r == 5'h0);
wire [3:0] spi_k = order ? (4'h8 - tx_left_r) : (tx_left_r - 4'h1); // R12

always @(posedge mclk or negedge rst_s_r) begin
    if (!rst_s_r) begin
        tx_hold_r  <= 9'h000;
        dre_r      <= 1'b1;
        txc_r      <= 1'b0;
        tx_busy_r  <= 1'b0;
        tx_frame_r <= 13'h1fff;
        tx_left_r  <= 4'h0;
        tx_tcnt_r  <= 5'h0;
        spi_rx_r   <= 8'h00;
        txd        <= 1'b1;
        xck        <= 1'b0;
        xck_oe     <= 1'b0;
    end else begin
        xck_oe <= clocked;
        if (wr_data && dre_r) begin
            tx_hold_r <= {enable_and_option_control_r[`CB_TX9], wdata};                // R5
            dre_r     <= 1'b0;
        end
        if (wr_stat && wdata[`ST_TXC])
            txc_r <= 1'b0;
        if (tx_load) begin
            dre_r      <= 1'b1;
            tx_busy_r  <= 1'b1;
            tx_frame_r <= frm;
            tx_left_r  <= len;
            tx_tcnt_r  <= 5'h0;
            txd        <= frm[0];
            xck        <= is_spi & phase;                          // R14
        end else if (tx_busy_r && tick) begin
            if (mid_strobe && is_spi)
                spi_rx_r[spi_k[2:0]] <= rxd_s_r;
            if (bit_end) begin
                tx_tcnt_r  <= 5'h0;
                tx_frame_r <= {1'b1, tx_frame_r[12:1]};
                tx_left_r  <= tx_left_r - 4'h1;
                if (tx_done) begin
                    tx_busy_r <= 1'b0;
                    txd       <= 1'b1;
                    xck       <= 1'b0;
                    if (dre_r)
                        txc_r <= 1'b1;
                end else begin
                    txd <= tx_frame_r[1];
                    xck <= is_spi & phase;                         // R14
                end
            end else begin
                tx_tcnt_r <= tx_tcnt_r + 5'h1;
                if (clocked)
                    xck <= ~(is_spi & phase);                      // R14
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// receiver

reg        rx_act_r;
reg  [3:0] rx_pos_r;
reg  [4:0] rx_tcnt_r;
reg  [8:0] rx_shift_r;
reg        rx_par_r;
reg  [8:0] rx_buf_r;
reg        rxc_r;
reg        ferr_r;
reg        parity_error_flag_r;
reg        ovf_r;

wire samp = is_spi ? 1'b0 :
            clocked ? (mid_strobe & (rx_act_r | ~rxd_s_r)) :
            (tick & rx_act_r & (rx_tcnt_r == 5'h1));
wire [3:0] stop_pos = n_cfg + 4'h1 + {3'h0, par_en};
wire fin       = samp & rx_act_r & (rx_pos_r == stop_pos);
wire addr_bit  = (n_cfg == 4'h9) ? rx_shift_r[8] : rxd_s_r;
wire rx_parity_error_flag_c = par_en & (^rx_shift_r ^ rx_par_r ^ odd);          // R9
wire del       = (fin & ~(multiproc_address_filter & ~addr_bit)) | (is_spi & tx_done); // R4
wire [8:0] del_word = is_spi ? {1'b0, spi_rx_r} : rx_shift_r;

always @(posedge mclk or negedge rst_s_r) begin
    if (!rst_s_r) begin
        rx_act_r   <= 1'b0;
        rx_pos_r   <= 4'h0;
        rx_tcnt_r  <= 5'h0;
        rx_shift_r <= 9'h000;
        rx_par_r   <= 1'b0;
        rx_buf_r   <= 9'h000;
        rxc_r      <= 1'b0;
        ferr_r     <= 1'b0;
        parity_error_flag_r     <= 1'b0;
        ovf_r      <= 1'b0;
    end else if (!rxen) begin
        rx_act_r <= 1'b0;
        rxc_r    <= 1'b0;
        ferr_r   <= 1'b0;
        parity_error_flag_r   <= 1'b0;
        ovf_r    <= 1'b0;
    end else begin
        if (rd_data) begin
            rxc_r  <= 1'b0;
            ferr_r <= 1'b0;
            parity_error_flag_r <= 1'b0;
            ovf_r  <= 1'b0;
        end
        if (wr_stat && wdata[`ST_RXC])
            rxc_r <= 1'b0;
        if (!clocked && !rx_act_r && rxd_d_r && !rxd_s_r) begin
            rx_act_r  <= 1'b1;
            rx_pos_r  <= 4'h0;
            rx_tcnt_r <= bit_ticks >> 1;
        end else if (!clocked && rx_act_r && tick)
            rx_tcnt_r <= (rx_tcnt_r == 5'h1) ? bit_ticks : rx_tcnt_r - 5'h1;
        if (samp) begin
            if (rx_pos_r == 4'h0) begin
                rx_act_r   <= ~rxd_s_r;
                rx_pos_r   <= 4'h1;
                rx_shift_r <= 9'h000;                              // R21
            end else if (rx_pos_r <= n_cfg) begin
                rx_shift_r[rx_pos_r - 4'h1] <= rxd_s_r;
                rx_pos_r <= rx_pos_r + 4'h1;
            end else if (!fin) begin
                rx_par_r <= rxd_s_r;
                rx_pos_r <= rx_pos_r + 4'h1;
            end else
                rx_act_r <= 1'b0;                                  // R10
        end
        if (del) begin
            if (rxc_r && !rd_data)
                ovf_r <= 1'b1;
            else begin
                rx_buf_r <= del_word;                              // R22
                rxc_r    <= 1'b1;
                ferr_r   <= ~is_spi & ~rxd_s_r;
                parity_error_flag_r   <= ~is_spi & rx_parity_error_flag_c;                   // R9
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// register port

wire [7:0] status = {rxc_r, txc_r, dre_r,
                     ~is_spi & ferr_r, ~is_spi & ovf_r, ~is_spi & parity_error_flag_r,
                     1'b0, ~is_spi & rx_buf_r[8]};                 // R22

always @(posedge mclk or negedge rst_s_r) begin
    if (!rst_s_r) begin
        interrupt_level_control_r     <= 6'h00;
        enable_and_option_control_r     <= 5'h00;
        frame_format_control_r     <= `FRAME_FORMAT_CONTROL_RST;
        baudl_r     <= `ZERO8;
        baudh_r     <= `ZERO8;
        act_baud_select_r  <= 12'h000;
        act_scale_r <= 4'h0;
        rdata       <= `ZERO8;
    end else begin
        if (wr_stb) begin
            case (addr)
                `OFS_INTERRUPT_LEVEL_CONTROL: interrupt_level_control_r <= wdata[5:0];
                `OFS_ENABLE_AND_OPTION_CONTROL: enable_and_option_control_r <= wdata[4:0];
                `OFS_FRAME_FORMAT_CONTROL: frame_format_control_r <= wdata;
                `OFS_BAUDL: begin
                    baudl_r     <= wdata;
                    act_baud_select_r  <= {baudh_r[3:0], wdata};          // R16 R17
                    act_scale_r <= baudh_r[7:4];
                end
                `OFS_BAUDH: baudh_r <= wdata;                      // R23
                default: ;
            endcase
        end
        if (rd_stb) begin
            case (addr)
                `OFS_DATA:   rdata <= rx_buf_r[7:0];
                `OFS_STATUS: rdata <= status;
                `OFS_INTERRUPT_LEVEL_CONTROL:  rdata <= {2'h0, interrupt_level_control_r};
                `OFS_ENABLE_AND_OPTION_CONTROL:  rdata <= {3'h0, enable_and_option_control_r};
                `OFS_FRAME_FORMAT_CONTROL:  rdata <= frame_format_control_r;
                `OFS_BAUDL:  rdata <= baudl_r;
                `OFS_BAUDH:  rdata <= baudh_r;
                default:     rdata <= `ZERO8;
            endcase
        end else
            rdata <= `ZERO8;
    end
end

endmodule // usart_frame_and_baud_config

// ### testbench/remote_echo.sv
// remote transceiver model: echoes the transmit line, records spi bits
// assumes xck comes from the block in clocked modes only
`timescale 1ns/1ns
module remote_echo (
    input  wire       mclk,
    input  wire       txd,
    input  wire       xck,
    input  wire       cpha,
    input  wire       clr,
    output reg        rxd,
    output reg  [7:0] cap,
    output reg  [4:0] edges
);
    reg xck_q;
    initial begin
        rxd = 1'b1;
        cap = 8'h00;
        edges = 5'h00;
        xck_q = 1'b0;
    end
    always @(posedge mclk) begin
        rxd <= txd;
        xck_q <= xck;
        if (clr) begin
            cap <= 8'h00;
            edges <= 5'h00;
        end else if (xck != xck_q && xck == !cpha) begin
            cap <= {txd, cap[7:1]};
            edges <= edges + 5'h01;
        end
    end
endmodule // remote_echo

// ### testbench/usart_cfg_properties.sv
// port checker for the serial configuration block
// assumes it is bound to the block and sees its ports only
`timescale 1ns/1ns
module usart_cfg_properties (
    input wire       mclk,
    input wire       rstn,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire       wr_stb,
    input wire       rd_stb,
    input wire [7:0] rdata,
    input wire       txd,
    input wire       xck,
    input wire       xck_oe
);
    reg  [1:0] mode_r;
    reg        seen_r;
    wire       wr_ctrl = wr_stb && addr == 3'h5;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= 2'h0;
            seen_r <= 1'b0;
        end else begin
            if (wr_ctrl) mode_r <= wdata[7:6];
            if (wr_stb && addr == 3'h0) seen_r <= 1'b1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence wr_rd(a);
        wr_stb && addr == a ##1 !wr_stb ##1 rd_stb && addr == a;
    endsequence
    sequence ctrl_quiet;
        (!wr_ctrl) [*3];
    endsequence
    a_frame_format_control_readback: assert property (wr_rd(3'h5) |=> rdata == $past(wdata, 3))
        else $error("frame format readback wrong");
    a_baud_low_kept: assert property (wr_rd(3'h6) |=> rdata == $past(wdata, 3))
        else $error("baud low readback wrong");
    a_baud_high_kept: assert property (wr_rd(3'h7) |=> rdata == $past(wdata, 3))
        else $error("baud high readback wrong");
    a_clock_pin_enable: assert property (ctrl_quiet |-> xck_oe == mode_r[0])
        else $error("clock pin enable does not follow mode");
    a_clock_idle_async: assert property (!xck_oe |-> !xck)
        else $error("clock pin toggles while not driven");
    a_tx_after_data: assert property ($fell(txd) |-> seen_r)
        else $error("frame started without data");
    a_rdata_quiet: assert property (rdata != 8'h00 |-> $past(rd_stb))
        else $error("read data outside read cycle");
    a_gap_read_zero: assert property (rd_stb && addr == 3'h2 |=> rdata == 8'h00)
        else $error("unmapped offset reads nonzero");
endmodule // usart_cfg_properties

bind usart_frame_and_baud_config usart_cfg_properties usart_cfg_properties_i (
    .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .txd(txd), .xck(xck), .xck_oe(xck_oe));

// ### testbench/usart_frame_and_baud_config_tb.sv
// self-checking bench for the serial configuration block
// assumes the partner echoes txd on rxd and records spi bits
`timescale 1ns/1ns
`include "usart_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module usart_frame_and_baud_config_tb;
    reg        mclk, rstn, wr_stb, rd_stb, cpha, clr;
    reg  [2:0] addr;
    reg  [7:0] wdata, r, d, e;
    wire [7:0] rdata, cap;
    wire [4:0] edges;
    wire       rxd, txd, xck, xck_oe;
    int        errors, checks, seed, q[$];
    reg  [7:0] rst_tab [8] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, `FRAME_FORMAT_CONTROL_RST, 8'h00, 8'h00};
    usart_frame_and_baud_config usart_frame_and_baud_config_i (.mclk(mclk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rxd(rxd), .txd(txd),
        .xck(xck), .xck_oe(xck_oe));
    remote_echo remote_echo_i (.mclk(mclk), .txd(txd), .xck(xck), .cpha(cpha), .clr(clr), .rxd(rxd),
        .cap(cap), .edges(edges));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task wr(input [2:0] a, input [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task rd(input [2:0] a, output [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 v = rdata;
    endtask
    // one frame over the echo line; len is the start bit in cycles, want 2 skips rx
    task xfer(input [7:0] cc, input [7:0] cb, input int len, input int want);
        int n;
        int b;
        wr(`OFS_FRAME_FORMAT_CONTROL, cc);
        wr(`OFS_ENABLE_AND_OPTION_CONTROL, cb);
        d = $random(seed) | 1;
        b = (cc[2:0] < 3'h4) ? 5 + cc[2:0] : 8;
        q.push_back(d & ((1 << b) - 1));
        wr(`OFS_DATA, d);
        n = 0;
        for (int k = 0; k < 99 && txd !== 1'b0; k++) @(posedge mclk);
        while (txd === 1'b0 && n < 999) begin
            @(posedge mclk);
            n++;
        end
        `CHK(n, len)
        repeat (13 * len + 40) @(posedge mclk);
        rd(`OFS_STATUS, r);
        if (want < 2) begin
            `CHK(r[`ST_RXC], want[0])
            `CHK(r[2], 1'b0)
        end
        if (cc[2:0] == `SIZE_9 && want == 1) `CHK(r[0], cb[0])
        rd(`OFS_DATA, r);
        e = q.pop_front();
        if (want == 1) `CHK(r, e)
        wr(`OFS_ENABLE_AND_OPTION_CONTROL, 8'h00);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        close_out;
    end
    initial begin
        seed = 58;
        errors = 0;
        checks = 0;
        rstn = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        cpha = 1'b0;
        clr = 1'b0;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], r);
            `CHK(r, rst_tab[a])
        end
        for (int a = 2; a < 8; a++) begin
            d = $random(seed);
            wr(a[2:0], d);
            rd(a[2:0], r);
            `CHK(r, d & (a == 2 ? 8'h00 : a == 3 ? 8'h3f : a == 4 ? 8'h1f : 8'hff))
        end
        wr(`OFS_ENABLE_AND_OPTION_CONTROL, 8'h00);
        wr(`OFS_BAUDH, 8'h00);
        wr(`OFS_BAUDL, 8'h00);
        xfer(8'h03, 8'h18, 16, 1);
        xfer(8'h20, 8'h1c, 8, 1);
        xfer(8'h39, 8'h18, 16, 1);
        xfer(8'h82, 8'h18, 16, 1);
        xfer(8'h07, 8'h19, 16, 1);
        xfer(8'h07, 8'h1a, 16, 0);
        xfer(8'h07, 8'h1b, 16, 1);
        xfer(8'h43, 8'h1c, 2, 2);
        wr(`OFS_BAUDH, 8'h10);
        xfer(8'h03, 8'h18, 16, 1);
        wr(`OFS_BAUDL, 8'h00);
        // one idle edge so the frame load lands on a tick of the halved rate
        @(posedge mclk);
        xfer(8'h03, 8'h18, 32, 1);
        wr(`OFS_BAUDH, 8'h00);
        wr(`OFS_BAUDL, 8'h00);
        for (int i = 0; i < 4; i++) begin
            cpha <= i[0];
            clr <= 1'b1;
            wr(`OFS_FRAME_FORMAT_CONTROL, {5'h18, i[1:0], 1'b0});
            clr <= 1'b0;
            wr(`OFS_ENABLE_AND_OPTION_CONTROL, 8'h1f);
            d = $random(seed);
            for (int k = 0; k < 8; k++) e[k] = d[7 - k];
            wr(`OFS_DATA, d);
            repeat (60) @(posedge mclk);
            `CHK(edges, 5'h08)
            `CHK(cap, i[1] ? d : e)
            wr(`OFS_ENABLE_AND_OPTION_CONTROL, 8'h00);
        end
        close_out;
    end
endmodule // usart_frame_and_baud_config_tb
